// file: hw/cace_cmd_exec.sv
// Coordinate table and accumulator command executor with framed byte link
// Contract
// [R1] Get special 0,255 restores entries 1..20
// [R2] Get special n,255 restores entry n
// [R3] Capture writes actual position to entry
// [R4] Persist setting chooses RAM or also store
// [R5] Entry zero never touches the store
// [R6] Capture replies OK with captured value
// [R7] Accu-to-coordinate copies accumulator to entry
// [R8] Accu-to-coordinate and calc reply OK
// [R9] Calc uses accu and X, result to accu
// [R10] Calc types 0..7 arithmetic and logic ops
// [R11] Calc type 8 inverts X
// [R12] Type 9 loads X, 10 swaps
// [R13] Accu-to-axis-param writes accumulator to parameter
// [R14] Nine-byte frame, value MSB first
// [R15] Instruction 1F decodes as get-coordinate
// [R16] Checksum is byte sum of eight
// [R17] Get: direct replies only, standalone loads accu
// [R18] Set special 255 saves RAM to store
// [R19] Table holds 21 signed 32-bit positions, entries 0..20
`timescale 1ns/1ns
module cace_cmd_exec
    import cace_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Command bytes from host
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    output logic rxReady,
    // Reply bytes to host
    output logic txValid,
    output logic [7:0] txData,
    input wire logic txReady,
    // Device context
    input wire logic standaloneMode,
    input wire logic persistEn,
    input wire logic signed [31:0] actualPos,
    input wire logic accuLoad,
    input wire logic [31:0] accuLoadVal,
    output logic [31:0] accuOut,
    output logic [31:0] xRegOut,
    // Axis parameter write
    output logic apStrobe,
    output logic [7:0] apNum,
    output logic [7:0] apMotor,
    output logic [31:0] apData,
    // Nonvolatile store
    output logic nvReq,
    output logic nvWrite,
    output logic [4:0] nvIdx,
    output logic [31:0] nvWdata,
    input wire logic nvAck,
    input wire logic [31:0] nvRdata
);
    cace_state_t state_q;
    logic [71:0] rxBuf_q;
    logic [3:0] rxCnt_q;
    logic [3:0] txCnt_q;
    logic [71:0] txShift_q;
    logic bootPend_q;
    logic silent_q;
    logic [4:0] nvIdx_q;
    logic [4:0] nvLast_q;
    logic nvWr_q;
    logic [31:0] nvWdata_q;
    logic signed [31:0] accu_q;
    logic signed [31:0] xReg_q;
    logic [31:0] coordTab_q [NUM_COORDS];
    logic apStrobe_q;
    logic [7:0] apNum_q;
    logic [7:0] apMotor_q;
    logic [31:0] apData_q;
    cace_cmd_t cmd;
    cace_reply_t reply;
    logic execOk;
    logic [7:0] status;
    logic [31:0] replyVal;
    logic ramWr;
    logic [31:0] ramData;
    logic nvGo;
    logic nvRd;
    logic [4:0] nvFirst;
    logic [4:0] nvLastD;
    logic accuWr;
    logic [31:0] accuNew;
    logic xWr;
    logic [31:0] xNew;
    logic apGo;
    logic [4:0] nxtIdx;

    assign cmd = cace_cmd_t'(rxBuf_q); // [R14]
    assign execOk = (state_q == ST_EXEC) && (cmd.addr == MODULE_ADDR);
    assign rxReady = (state_q == ST_IDLE) && !bootPend_q;
    assign txValid = (state_q == ST_SEND);
    assign txData = txShift_q[71:64];
    assign nvReq = (state_q == ST_NV);
    assign nvWrite = nvWr_q;
    assign nvIdx = nvIdx_q;
    assign nvWdata = nvWdata_q;
    assign accuOut = accu_q;
    assign xRegOut = xReg_q;
    assign apStrobe = apStrobe_q;
    assign apNum = apNum_q;
    assign apMotor = apMotor_q;
    assign apData = apData_q;
    assign nxtIdx = nvIdx_q + 5'h01;

    // Decode of the held frame
    always_comb
    begin
        status = ST_OK;
        replyVal = 32'h0;
        ramWr = 1'b0;
        ramData = cmd.value;
        nvGo = 1'b0;
        nvRd = 1'b0;
        nvFirst = cmd.typ[4:0];
        nvLastD = cmd.typ[4:0];
        accuWr = 1'b0;
        accuNew = accu_q;
        xWr = 1'b0;
        xNew = xReg_q;
        apGo = 1'b0;
        if (cace_sum8(rxBuf_q[71:8]) != cmd.csum) // [R16]
        begin
            status = ST_BAD_SUM;
        end
        else
        begin
            case (cmd.instr)
                INS_SET_COORD, INS_GET_COORD, INS_CAPTURE, INS_ACCU_COORD:
                begin
                    if (cmd.typ > MAX_COORD) // [R19]
                    begin
                        status = ST_BAD_TYPE;
                    end
                    else if (cmd.motor == MOTOR_SPECIAL
                        && (cmd.instr == INS_SET_COORD || cmd.instr == INS_GET_COORD))
                    begin
                        nvGo = 1'b1; // [R18]
                        nvRd = (cmd.instr == INS_GET_COORD); // [R1] [R2]
                        if (cmd.typ == 8'h00)
                        begin
                            nvFirst = FIRST_NV_IDX; // [R5]
                            nvLastD = LAST_IDX;
                        end
                    end
                    else if (cmd.motor != MOTOR_ID)
                    begin
                        status = ST_BAD_VALUE;
                    end
                    else
                    begin
                        case (cmd.instr)
                            INS_SET_COORD:
                            begin
                                ramWr = 1'b1;
                            end
                            INS_GET_COORD: // [R15]
                            begin
                                replyVal = coordTab_q[cmd.typ[4:0]];
                                accuWr = standaloneMode; // [R17]
                                accuNew = coordTab_q[cmd.typ[4:0]];
                            end
                            INS_CAPTURE:
                            begin
                                ramWr = 1'b1; // [R3]
                                ramData = actualPos;
                                replyVal = actualPos; // [R6]
                            end
                            default:
                            begin
                                ramWr = 1'b1; // [R7]
                                ramData = accu_q;
                            end
                        endcase
                        // Entry zero stays volatile
                        nvGo = ramWr && persistEn && (cmd.typ != 8'h00); // [R4] [R5]
                    end
                end
                INS_CALC_WITH_X_CMD:
                begin
                    accuWr = 1'b1; // [R9] [R8]
                    case (cmd.typ) // [R10]
                        CX_ADD: accuNew = accu_q + xReg_q;
                        CX_SUB: accuNew = accu_q - xReg_q;
                        CX_MUL: accuNew = accu_q * xReg_q;
                        // Divide by zero leaves the accumulator as it was
                        CX_DIV: accuNew = (xReg_q == 0) ? accu_q : accu_q / xReg_q;
                        CX_MOD: accuNew = (xReg_q == 0) ? accu_q : accu_q % xReg_q;
                        CX_AND: accuNew = accu_q & xReg_q;
                        CX_OR: accuNew = accu_q | xReg_q;
                        CX_XOR: accuNew = accu_q ^ xReg_q;
                        CX_NOT:
                        begin
                            accuWr = 1'b0;
                            xWr = 1'b1;
                            xNew = ~xReg_q; // [R11]
                        end
                        CX_LOAD:
                        begin
                            accuWr = 1'b0;
                            xWr = 1'b1;
                            xNew = accu_q; // [R12]
                        end
                        CX_SWAP:
                        begin
                            xWr = 1'b1;
                            xNew = accu_q; // [R12]
                            accuNew = xReg_q;
                        end
                        default:
                        begin
                            accuWr = 1'b0;
                            status = ST_BAD_TYPE;
                        end
                    endcase
                end
                INS_ACCU_AXIS:
                begin
                    apGo = (cmd.motor == MOTOR_ID); // [R13]
                    if (cmd.motor != MOTOR_ID)
                    begin
                        status = ST_BAD_VALUE;
                    end
                end
                default:
                begin
                    status = ST_BAD_CMD;
                end
            endcase
        end
        reply.hostAddr = HOST_ADDR;
        reply.modAddr = MODULE_ADDR;
        reply.status = status;
        reply.instr = cmd.instr;
        reply.value = replyVal;
        reply.csum = 8'h00;
        reply.csum = cace_sum8(reply[71:8]); // [R16]
    end

    // Sequencer
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q <= ST_IDLE;
            rxCnt_q <= 4'h0;
            txCnt_q <= 4'h0;
            bootPend_q <= 1'b1;
            silent_q <= 1'b0;
            nvIdx_q <= FIRST_NV_IDX;
            nvLast_q <= FIRST_NV_IDX;
            nvWr_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (bootPend_q)
                    begin
                        // Startup restore only when persistence is on
                        bootPend_q <= 1'b0;
                        if (persistEn) // [R4] [R5]
                        begin
                            nvIdx_q <= FIRST_NV_IDX;
                            nvLast_q <= LAST_IDX;
                            nvWr_q <= 1'b0;
                            silent_q <= 1'b1;
                            state_q <= ST_NV;
                        end
                    end
                    else if (rxValid)
                    begin
                        rxCnt_q <= (rxCnt_q == LAST_BYTE) ? 4'h0 : rxCnt_q + 4'h1; // [R14]
                        if (rxCnt_q == LAST_BYTE)
                        begin
                            state_q <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC:
                begin
                    silent_q <= 1'b0;
                    txCnt_q <= 4'h0;
                    nvIdx_q <= nvFirst;
                    nvLast_q <= nvLastD;
                    nvWr_q <= !nvRd;
                    if (cmd.addr != MODULE_ADDR)
                    begin
                        // Frames for other modules get no reply
                        state_q <= ST_IDLE;
                    end
                    else
                    begin
                        state_q <= nvGo ? ST_NV : ST_SEND;
                    end
                end
                ST_NV:
                begin
                    if (nvAck)
                    begin
                        nvIdx_q <= nxtIdx;
                        if (nvIdx_q == nvLast_q)
                        begin
                            state_q <= silent_q ? ST_IDLE : ST_SEND;
                        end
                    end
                end
                ST_SEND:
                begin
                    if (txReady)
                    begin
                        txCnt_q <= txCnt_q + 4'h1;
                        if (txCnt_q == LAST_BYTE)
                        begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Frame capture and reply shifting
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rxBuf_q <= 72'h0;
            txShift_q <= 72'h0;
        end
        else
        begin
            if (rxValid && rxReady)
            begin
                rxBuf_q <= {rxBuf_q[63:0], rxData};
            end
            if (execOk)
            begin
                txShift_q <= reply;
            end
            else if (state_q == ST_SEND && txReady)
            begin
                txShift_q <= {txShift_q[63:0], 8'h00};
            end
        end
    end

    // Coordinate table; store reads and command writes never coincide
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < NUM_COORDS; i++)
            begin
                coordTab_q[i] <= 32'h0;
            end
        end
        else if (execOk && ramWr)
        begin
            coordTab_q[cmd.typ[4:0]] <= ramData; // [R3] [R7]
        end
        else if (state_q == ST_NV && nvAck && !nvWr_q)
        begin
            coordTab_q[nvIdx_q] <= nvRdata; // [R1] [R2]
        end
    end

    // Store write data follows the index
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            nvWdata_q <= 32'h0;
        end
        else if (execOk)
        begin
            nvWdata_q <= ramWr ? ramData : coordTab_q[nvFirst];
        end
        else if (state_q == ST_NV && nvAck && nvIdx_q != nvLast_q)
        begin
            nvWdata_q <= coordTab_q[nxtIdx]; // [R18]
        end
    end

    // Accumulator and X register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            accu_q <= 32'h0;
            xReg_q <= 32'h0;
        end
        else
        begin
            if (execOk && accuWr)
            begin
                accu_q <= accuNew; // [R9]
            end
            else if (accuLoad)
            begin
                accu_q <= accuLoadVal;
            end
            if (execOk && xWr)
            begin
                xReg_q <= xNew;
            end
        end
    end

    // Axis parameter strobe
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            apStrobe_q <= 1'b0;
            apNum_q <= 8'h00;
            apMotor_q <= 8'h00;
            apData_q <= 32'h0;
        end
        else
        begin
            apStrobe_q <= execOk && apGo;
            if (execOk && apGo)
            begin
                apNum_q <= cmd.typ; // [R13]
                apMotor_q <= cmd.motor;
                apData_q <= accu_q;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence sFrameDone;
        rxValid && rxReady && rxCnt_q == LAST_BYTE;
    endsequence
    sequence sExecGood(logic [7:0] ins);
        execOk && cace_sum8(rxBuf_q[71:8]) == cmd.csum && cmd.instr == ins;
    endsequence

    frame_end_a: assert property (sFrameDone |=> state_q == ST_EXEC) // [R14]
        else $error("frame end not followed by execute");
    nv_entry0_a: assert property (nvReq |-> nvIdx_q != 5'h00) // [R5]
        else $error("entry zero reached the store");
    ram_only_a: assert property (sExecGood(INS_CAPTURE) && !persistEn |=> state_q == ST_SEND) // [R4]
        else $error("store used with persistence off");
    restore_rd_a: assert property (nvReq && nvAck && !nvWrite // [R1]
        |=> coordTab_q[$past(nvIdx_q)] == $past(nvRdata))
        else $error("restored entry not written");
    capture_ok_a: assert property (sExecGood(INS_CAPTURE) && cmd.typ <= MAX_COORD // [R3] [R6]
        && cmd.motor == MOTOR_ID |=> coordTab_q[$past(cmd.typ[4:0])] == $past(actualPos)
        && txShift_q[55:48] == ST_OK && txShift_q[39:8] == $past(actualPos))
        else $error("capture wrong");
    calc_add_a: assert property (sExecGood(INS_CALC_WITH_X_CMD) && cmd.typ == CX_ADD // [R10] [R8]
        |=> accu_q == $past(accu_q) + $past(xReg_q) && txShift_q[55:48] == ST_OK)
        else $error("calc add wrong");
    calc_swap_a: assert property (sExecGood(INS_CALC_WITH_X_CMD) && cmd.typ == CX_SWAP // [R12]
        |=> accu_q == $past(xReg_q) && xReg_q == $past(accu_q))
        else $error("swap wrong");
    calc_not_a: assert property (sExecGood(INS_CALC_WITH_X_CMD) && cmd.typ == CX_NOT && !accuLoad // [R11]
        |=> xReg_q == ~$past(xReg_q) && accu_q == $past(accu_q))
        else $error("invert wrong");
    gco_direct_a: assert property (sExecGood(INS_GET_COORD) && !standaloneMode // [R17]
        && !accuLoad |=> accu_q == $past(accu_q))
        else $error("direct get changed accumulator");
    axis_param_a: assert property (sExecGood(INS_ACCU_AXIS) && cmd.motor == MOTOR_ID // [R13]
        |=> apStrobe && apData == $past(accu_q) ##1 !apStrobe)
        else $error("axis parameter transfer wrong");
    reply_sum_a: assert property (txValid && txCnt_q == 4'h0 // [R16]
        |-> txShift_q[7:0] == cace_sum8(txShift_q[71:8]))
        else $error("reply checksum wrong");
endmodule

// file: hw/cace_pkg.sv
// Constants, frame layouts and states for the coordinate and accumulator command executor
package cace_pkg;
    // Instruction codes
    localparam logic [7:0] INS_SET_COORD = 8'h1e;
    localparam logic [7:0] INS_GET_COORD = 8'h1f;
    localparam logic [7:0] INS_CAPTURE = 8'h20;
    localparam logic [7:0] INS_CALC_WITH_X_CMD = 8'h21;
    localparam logic [7:0] INS_ACCU_AXIS = 8'h22;
    localparam logic [7:0] INS_ACCU_COORD = 8'h27;
    // Calculate-with-X type codes
    localparam logic [7:0] CX_ADD = 8'h00;
    localparam logic [7:0] CX_SUB = 8'h01;
    localparam logic [7:0] CX_MUL = 8'h02;
    localparam logic [7:0] CX_DIV = 8'h03;
    localparam logic [7:0] CX_MOD = 8'h04;
    localparam logic [7:0] CX_AND = 8'h05;
    localparam logic [7:0] CX_OR = 8'h06;
    localparam logic [7:0] CX_XOR = 8'h07;
    localparam logic [7:0] CX_NOT = 8'h08;
    localparam logic [7:0] CX_LOAD = 8'h09;
    localparam logic [7:0] CX_SWAP = 8'h0a;
    // Reply status codes
    localparam logic [7:0] ST_OK = 8'h64;
    localparam logic [7:0] ST_BAD_SUM = 8'h01;
    localparam logic [7:0] ST_BAD_CMD = 8'h02;
    localparam logic [7:0] ST_BAD_TYPE = 8'h03;
    localparam logic [7:0] ST_BAD_VALUE = 8'h04;
    // Addressing and table shape
    localparam logic [7:0] MODULE_ADDR = 8'h01;
    localparam logic [7:0] HOST_ADDR = 8'h02;
    localparam logic [7:0] MOTOR_ID = 8'h00;
    localparam logic [7:0] MOTOR_SPECIAL = 8'hff;
    localparam logic [7:0] MAX_COORD = 8'h14;
    localparam logic [4:0] LAST_IDX = 5'h14;
    localparam logic [4:0] FIRST_NV_IDX = 5'h01;
    localparam int NUM_COORDS = 21;
    localparam logic [3:0] LAST_BYTE = 4'h8;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] instr;
        logic [7:0] typ;
        logic [7:0] motor;
        logic [31:0] value;
        logic [7:0] csum;
    } cace_cmd_t;

    typedef struct packed {
        logic [7:0] hostAddr;
        logic [7:0] modAddr;
        logic [7:0] status;
        logic [7:0] instr;
        logic [31:0] value;
        logic [7:0] csum;
    } cace_reply_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_NV = 2'b11,
        ST_SEND = 2'b10
    } cace_state_t;

    function automatic logic [7:0] cace_sum8(input logic [63:0] b);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            s = s + b[i*8 +: 8];
        end
        return s;
    endfunction
endpackage

// file: tb/cace_nv_model.sv
// Behavioural nonvolatile coordinate store answering the executor
`timescale 1ns/1ns
module cace_nv_model
(
    // Clock
    input wire logic clk,
    // Store access
    input wire logic nvReq,
    input wire logic nvWrite,
    input wire logic [4:0] nvIdx,
    input wire logic [31:0] nvWdata,
    output logic nvAck,
    output logic [31:0] nvRdata
);
    logic [31:0] mem [0:20];
    int lat = 2;
    int waitQ = 0;
    int writes = 0;
    int reads = 0;
    int zeroHits = 0;

    initial
    begin
        for (int i = 0; i <= 20; i++)
        begin
            mem[i] = 32'h00a00000 + i;
        end
        nvAck = 1'b0;
        nvRdata = 32'h00000000;
    end

    // Settable latency gives quick and slow answers
    always @(posedge clk)
    begin
        nvAck <= 1'b0;
        if (nvReq && !nvAck)
        begin
            if (waitQ >= lat)
            begin
                nvAck <= 1'b1;
                waitQ <= 0;
                if (nvIdx == 5'h00)
                begin
                    zeroHits <= zeroHits + 1;
                end
                if (nvWrite)
                begin
                    mem[nvIdx] <= nvWdata;
                    writes <= writes + 1;
                end
                else
                begin
                    nvRdata <= mem[nvIdx];
                    reads <= reads + 1;
                end
            end
            else
            begin
                waitQ <= waitQ + 1;
            end
        end
        else if (!nvAck)
        begin
            // Read data is not held once the request drops
            nvRdata <= ~nvRdata;
        end
    end
endmodule

// file: tb/tb_cace_cmd_exec.sv
// Self-checking bench for the coordinate and accumulator executor
`timescale 1ns/1ns
module tb_cace_cmd_exec;
    import cace_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rxValid = 1'b0;
    logic [7:0] rxData = 8'h00;
    logic rxReady, txValid, txReady = 1'b1;
    logic [7:0] txData;
    logic standaloneMode = 1'b0;
    logic persistEn = 1'b0;
    logic signed [31:0] actualPos = 32'sh00000000;
    logic accuLoad = 1'b0;
    logic [31:0] accuLoadVal = 32'h00000000;
    logic [31:0] accuOut, xRegOut, apData, nvWdata, nvRdata;
    logic apStrobe, nvReq, nvWrite, nvAck;
    logic [7:0] apNum, apMotor;
    logic [4:0] nvIdx;
    logic [7:0] st;
    logic [31:0] rv;
    int mismatches = 0;
    int total_checks = 0;
    int apCount = 0;
    logic [31:0] apSeen;
    logic [7:0] apNumSeen;

    always #20 clk = ~clk;

    cace_cmd_exec cace_cmd_exec_inst (.clk(clk), .srst(srst), .rxValid(rxValid),
        .rxData(rxData), .rxReady(rxReady), .txValid(txValid), .txData(txData),
        .txReady(txReady), .standaloneMode(standaloneMode), .persistEn(persistEn),
        .actualPos(actualPos), .accuLoad(accuLoad), .accuLoadVal(accuLoadVal),
        .accuOut(accuOut), .xRegOut(xRegOut), .apStrobe(apStrobe), .apNum(apNum),
        .apMotor(apMotor), .apData(apData), .nvReq(nvReq), .nvWrite(nvWrite),
        .nvIdx(nvIdx), .nvWdata(nvWdata), .nvAck(nvAck), .nvRdata(nvRdata));

    cace_nv_model nvModel (.clk(clk), .nvReq(nvReq), .nvWrite(nvWrite), .nvIdx(nvIdx),
        .nvWdata(nvWdata), .nvAck(nvAck), .nvRdata(nvRdata));

    always @(posedge clk)
    begin
        if (apStrobe === 1'b1)
        begin
            apCount <= apCount + 1;
            apSeen <= apData;
            apNumSeen <= apNum;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] bsum(input logic [63:0] b);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            s = s + b[i*8 +: 8];
        end
        return s;
    endfunction

    // Frame out, reply back and judged
    task automatic xfer(input logic [7:0] ins, input logic [7:0] typ, input logic [7:0] mot,
        input logic [31:0] val, input logic bad);
        logic [71:0] f;
        logic [71:0] r;
        int n;
        f[71:8] = {MODULE_ADDR, ins, typ, mot, val};
        f[7:0] = bsum(f[71:8]) + {7'h00, bad};
        for (int i = 8; i >= 0; i--)
        begin
            n = 0;
            @(negedge clk);
            while (rxReady !== 1'b1 && n < 2000)
            begin
                n++;
                @(negedge clk);
            end
            rxValid = 1'b1;
            rxData = f[i*8 +: 8];
        end
        @(negedge clk);
        rxValid = 1'b0;
        for (int i = 8; i >= 0; i--)
        begin
            n = 0;
            @(negedge clk);
            while (txValid !== 1'b1 && n < 2000)
            begin
                n++;
                @(negedge clk);
            end
            r[i*8 +: 8] = txData;
        end
        chk({16'h0000, r[71:56]}, {16'h0000, HOST_ADDR, MODULE_ADDR});
        chk(32'(r[47:40]), 32'(ins));
        chk(32'(r[7:0]), 32'(bsum(r[71:8])));
        st = r[55:48];
        rv = r[39:8];
    endtask

    task automatic load(input logic [31:0] v);
        @(negedge clk);
        accuLoad = 1'b1;
        accuLoadVal = v;
        @(negedge clk);
        accuLoad = 1'b0;
    endtask

    function automatic logic [31:0] calc_ref(input int t, input logic [31:0] a,
        input logic [31:0] x);
        case (t)
            0: return a + x;
            1: return a - x;
            2: return a * x;
            3: return $signed(a) / $signed(x);
            4: return $signed(a) % $signed(x);
            5: return a & x;
            6: return a | x;
            default: return a ^ x;
        endcase
    endfunction

    task automatic t_calc();
        load(32'h00000003);
        xfer(INS_CALC_WITH_X_CMD, CX_LOAD, 8'h00, 32'h0, 1'b0);
        chk(xRegOut, 32'h00000003);
        for (int t = 0; t < 8; t++)
        begin
            load(32'hfffffff9);
            xfer(INS_CALC_WITH_X_CMD, 8'(t), 8'h00, 32'h0, 1'b0);
            chk(32'(st), 32'(ST_OK));
            chk(accuOut, calc_ref(t, 32'hfffffff9, 32'h00000003));
        end
        xfer(INS_CALC_WITH_X_CMD, CX_NOT, 8'h00, 32'h0, 1'b0);
        chk(xRegOut, 32'hfffffffc);
        load(32'h00000055);
        xfer(INS_CALC_WITH_X_CMD, CX_SWAP, 8'h00, 32'h0, 1'b0);
        chk(accuOut, 32'hfffffffc);
        chk(xRegOut, 32'h00000055);
    endtask

    task automatic t_coord();
        load(32'h12345678);
        xfer(INS_ACCU_COORD, 8'h05, MOTOR_ID, 32'h0, 1'b0);
        chk(32'(st), 32'(ST_OK));
        load(32'h00000000);
        xfer(INS_GET_COORD, 8'h05, MOTOR_ID, 32'h0, 1'b0);
        chk(rv, 32'h12345678);
        chk(accuOut, 32'h00000000);
        standaloneMode = 1'b1;
        xfer(INS_GET_COORD, 8'h05, MOTOR_ID, 32'h0, 1'b0);
        chk(accuOut, 32'h12345678);
        standaloneMode = 1'b0;
        chk(32'(nvModel.writes), 32'h0);
    endtask

    task automatic t_boot();
        persistEn = 1'b1;
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        xfer(INS_GET_COORD, 8'h05, MOTOR_ID, 32'h0, 1'b0);
        chk(rv, 32'h00a00005);
        persistEn = 1'b0;
    endtask

    task automatic t_capture();
        persistEn = 1'b1;
        actualPos = -32'sd1000;
        xfer(INS_CAPTURE, 8'h14, MOTOR_ID, 32'h0, 1'b0);
        chk(32'(st), 32'(ST_OK));
        chk(rv, 32'hfffffc18);
        chk(nvModel.mem[20], 32'hfffffc18);
        chk(32'(nvModel.writes), 32'h1);
        xfer(INS_CAPTURE, 8'h00, MOTOR_ID, 32'h0, 1'b0);
        chk(32'(nvModel.writes), 32'h1);
        persistEn = 1'b0;
        xfer(INS_GET_COORD, 8'h14, MOTOR_ID, 32'h0, 1'b0);
        chk(rv, 32'hfffffc18);
    endtask

    task automatic t_restore();
        nvModel.lat = 0;
        xfer(INS_GET_COORD, 8'h00, MOTOR_SPECIAL, 32'h0, 1'b0);
        chk(32'(nvModel.reads), 32'd40);
        xfer(INS_GET_COORD, 8'h05, MOTOR_ID, 32'h0, 1'b0);
        chk(rv, 32'h00a00005);
        xfer(INS_GET_COORD, 8'h00, MOTOR_ID, 32'h0, 1'b0);
        chk(rv, 32'hfffffc18);
        nvModel.lat = 6;
        nvModel.mem[3] = 32'h0000beef;
        xfer(INS_GET_COORD, 8'h03, MOTOR_SPECIAL, 32'h0, 1'b0);
        chk(32'(nvModel.reads), 32'd41);
        xfer(INS_GET_COORD, 8'h03, MOTOR_ID, 32'h0, 1'b0);
        chk(rv, 32'h0000beef);
        chk(32'(nvModel.zeroHits), 32'h0);
        xfer(INS_SET_COORD, 8'h07, MOTOR_ID, 32'h00007777, 1'b0);
        xfer(INS_SET_COORD, 8'h07, MOTOR_SPECIAL, 32'h0, 1'b0);
        chk(nvModel.mem[7], 32'h00007777);
        xfer(INS_SET_COORD, 8'h00, MOTOR_SPECIAL, 32'h0, 1'b0);
        chk(32'(nvModel.writes), 32'd22);
    endtask

    task automatic t_axis();
        load(32'h0badcafe);
        xfer(INS_ACCU_AXIS, 8'h04, MOTOR_ID, 32'h0, 1'b0);
        chk(32'(apCount), 32'h1);
        chk({16'h0000, apMotor, apNumSeen}, 32'h4);
        chk(apSeen, 32'h0badcafe);
    endtask

    task automatic t_badsum();
        xfer(INS_GET_COORD, 8'h05, MOTOR_ID, 32'h0, 1'b1);
        chk(32'(st), 32'(ST_BAD_SUM));
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Whole run needs well under 20000 cycles
    initial
    begin
        #(40 * 20000);
        mismatches++;
        give_verdict();
    end

    initial
    begin
        repeat (4) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        t_calc();
        t_coord();
        t_boot();
        t_capture();
        t_restore();
        t_axis();
        t_badsum();
        give_verdict();
    end
endmodule
